/* rtl/sbc_ctrl.sv */
// Serial bus control and status logic with Wishbone register slave
`timescale 1ns/1ps
module sbc_ctrl #(
   parameter int HALF = sbc_pkg::HALF_CYC
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic arst_n,
   // Wishbone classic slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [11:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // Two-wire bus, open drain
   input wire logic scl_in,
   output logic scl_out,
   output logic scl_oe,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   // Interrupt
   output logic irq
);
   sbc_pkg::sbc_ctl_t ctl;
   sbc_pkg::sbc_state_t st;
   sbc_pkg::sbc_pins_t bus;
   sbc_pkg::sbc_pins_t bus_d;
   logic [4:0] code;
   logic [sbc_pkg::EV_W-1:0] ev_sts;
   logic [sbc_pkg::EV_W-1:0] ev_mask;
   logic [sbc_pkg::EV_W-1:0] ev_set;
   logic [1:0] ien;
   logic busy;
   logic master;
   logic sent;
   logic [15:0] cnt;
   logic half_done;
   logic start_seen;
   logic stop_seen;
   logic req;
   logic wr;
   logic [7:0] idx;
   logic si_set;
   logic stop_clr;
   logic [4:0] next_code;

   // Pin synchronisers
   sbc_sync #(.INIT(1'b1)) u_scl (
      .mclk(mclk),
      .arst_n(arst_n),
      .pin(scl_in),
      .level(bus.scl)
   );
   sbc_sync #(.INIT(1'b1)) u_sda (
      .mclk(mclk),
      .arst_n(arst_n),
      .pin(sda_in),
      .level(bus.sda)
   );

   // Bus decode
   assign req = cyc_i & stb_i & ~ack_o;
   assign wr = req & we_i & sel_i[0];
   assign idx = adr_i[9:2];

   // Bus condition detect on filtered levels
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         bus_d <= '1;
      end else begin
         bus_d <= bus;
      end
   end
   assign start_seen = bus.scl & bus_d.scl & bus_d.sda & ~bus.sda;
   assign stop_seen = bus.scl & bus_d.scl & ~bus_d.sda & bus.sda;

   // Bus busy between any START and STOP while the interface is on; cleared when it is off
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         busy <= 1'b0;
      end else if (!ctl.interface_on) begin
         busy <= 1'b0;
      end else if (start_seen) begin
         busy <= 1'b1;
      end else if (stop_seen) begin
         busy <= 1'b0;
      end
   end

   // Half bit period timer, restarted on every state change
   assign half_done = (cnt == 16'(HALF - 1));

   // Master sequencer
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         st <= sbc_pkg::ST_IDLE;
         cnt <= '0;
         master <= 1'b0;
         sent <= 1'b0;
      end else if (!ctl.interface_on) begin
         st <= sbc_pkg::ST_IDLE;
         cnt <= '0;
         master <= 1'b0;
         sent <= 1'b0;
      end else begin
         cnt <= half_done ? '0 : cnt + 16'h0001;
         unique case (st)
            sbc_pkg::ST_IDLE: begin
               cnt <= '0;
               if (ctl.stop_request) begin
                  master <= 1'b0;
               end else if (ctl.start_request) begin
                  master <= 1'b1;
                  sent <= 1'b0;
                  st <= busy ? sbc_pkg::ST_WAIT_FREE : sbc_pkg::ST_START;
               end
            end
            sbc_pkg::ST_WAIT_FREE: begin
               cnt <= '0;
               if (stop_seen || !busy) begin
                  st <= sbc_pkg::ST_WAIT_HALF;
               end
            end
            sbc_pkg::ST_WAIT_HALF: begin
               if (busy) begin
                  st <= sbc_pkg::ST_WAIT_FREE;
               end else if (half_done) begin
                  st <= sbc_pkg::ST_START;
               end
            end
            sbc_pkg::ST_START: begin
               if (half_done) begin
                  st <= sbc_pkg::ST_OWN;
                  sent <= 1'b1;
               end
            end
            sbc_pkg::ST_OWN: begin
               cnt <= '0;
               // Bus held with clock low until the flag is cleared with a START or STOP request set
               if (!ctl.si) begin
                  if (ctl.stop_request) begin
                     st <= sbc_pkg::ST_STOP_LOW;
                  end else if (ctl.start_request) begin
                     st <= sbc_pkg::ST_RS_SDA;
                  end
               end
            end
            sbc_pkg::ST_RS_SDA: begin
               if (half_done) begin
                  st <= sbc_pkg::ST_RS_SCL;
               end
            end
            sbc_pkg::ST_RS_SCL: begin
               if (half_done) begin
                  st <= sbc_pkg::ST_START;
               end
            end
            sbc_pkg::ST_STOP_LOW: begin
               if (half_done) begin
                  st <= sbc_pkg::ST_STOP_SCL;
               end
            end
            sbc_pkg::ST_STOP_SCL: begin
               if (half_done) begin
                  st <= sbc_pkg::ST_STOP_SDA;
               end
            end
            sbc_pkg::ST_STOP_SDA: begin
               cnt <= '0;
               // Leave only once our own STOP is seen on the wires
               if (stop_seen) begin
                  st <= sbc_pkg::ST_IDLE;
                  master <= 1'b0;
                  sent <= 1'b0;
               end
            end
            default: begin
               st <= sbc_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // Pin drive from state; enable high means pull low
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         scl_oe <= 1'b0;
         sda_oe <= 1'b0;
      end else begin
         scl_oe <= st == sbc_pkg::ST_OWN || st == sbc_pkg::ST_RS_SDA || st == sbc_pkg::ST_STOP_LOW;
         sda_oe <= st == sbc_pkg::ST_START || st == sbc_pkg::ST_OWN || st == sbc_pkg::ST_STOP_LOW
                   || st == sbc_pkg::ST_STOP_SCL;
      end
   end

   // Open-drain outputs only ever drive low
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         scl_out <= 1'b0;
         sda_out <= 1'b0;
      end else begin
         scl_out <= 1'b0;
         sda_out <= 1'b0;
      end
   end

   // Protocol state entered: START sent or repeated START sent
   assign si_set = ctl.interface_on && st == sbc_pkg::ST_START && half_done;
   assign stop_clr = (st == sbc_pkg::ST_STOP_SDA && stop_seen)
                    || (st == sbc_pkg::ST_IDLE && ctl.stop_request);

   // Next state code
   always_comb begin
      next_code = code;
      if (!ctl.interface_on) begin
         next_code = sbc_pkg::CODE_IDLE;
      end else if (si_set) begin
         next_code = sent ? sbc_pkg::CODE_RESTART : sbc_pkg::CODE_START;
      end else if (stop_clr) begin
         next_code = sbc_pkg::CODE_IDLE;
      end else if (!ctl.si) begin
         next_code = sbc_pkg::CODE_IDLE;
      end
   end

   // State code; bus writes never reach it
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         code <= sbc_pkg::CODE_RESET;
      end else begin
         code <= next_code;
      end
   end

   // Control register; hardware set beats software clear
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         ctl <= '0;
      end else begin
         if (wr && idx == sbc_pkg::IDX_CONTROL) begin
            ctl.interface_on <= dat_i[sbc_pkg::CTL_ON];
            ctl.start_request <= dat_i[sbc_pkg::CTL_START];
            ctl.stop_request <= dat_i[sbc_pkg::CTL_STOP];
            ctl.aa <= dat_i[sbc_pkg::CTL_AA];
            ctl.crsel <= dat_i[sbc_pkg::CTL_CRSEL];
            // Only a zero does anything to the flag
            if (!dat_i[sbc_pkg::CTL_SI]) begin
               ctl.si <= 1'b0;
            end
         end
         if (stop_clr) begin
            ctl.stop_request <= 1'b0;
         end
         if (si_set) begin
            ctl.si <= 1'b1;
         end
      end
   end

   // Event sources for the sticky status
   assign ev_set = {stop_clr && !master, stop_seen, si_set};

   // Sticky status, write one to clear, set wins
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         ev_sts <= '0;
      end else if (wr && idx == sbc_pkg::IDX_IRQ_STATUS) begin
         ev_sts <= (ev_sts & ~dat_i[sbc_pkg::EV_W-1:0]) | ev_set;
      end else begin
         ev_sts <= ev_sts | ev_set;
      end
   end

   // Mask and enable registers
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         ev_mask <= '0;
         ien <= '0;
      end else begin
         if (wr && idx == sbc_pkg::IDX_IRQ_MASK) begin
            ev_mask <= dat_i[sbc_pkg::EV_W-1:0];
         end
         if (wr && idx == sbc_pkg::IDX_IRQ_ENABLE) begin
            ien <= dat_i[1:0];
         end
      end
   end

   // Interrupt level
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         irq <= 1'b0;
      end else begin
         irq <= (ctl.si & ien[sbc_pkg::IEN_GLOBAL] & ien[sbc_pkg::IEN_SERIAL])
                | (|(ev_sts & ev_mask));
      end
   end

   // Acknowledge one cycle after the request, dropped the next
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         ack_o <= 1'b0;
      end else begin
         ack_o <= req;
      end
   end

   // Read data; unmapped indices read zero
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         dat_o <= '0;
      end else if (req && !we_i) begin
         dat_o <= '0;
         unique case (idx)
            sbc_pkg::IDX_CONTROL: begin
               dat_o[sbc_pkg::CTL_ON] <= ctl.interface_on;
               dat_o[sbc_pkg::CTL_START] <= ctl.start_request;
               dat_o[sbc_pkg::CTL_STOP] <= ctl.stop_request;
               dat_o[sbc_pkg::CTL_SI] <= ctl.si;
               dat_o[sbc_pkg::CTL_AA] <= ctl.aa;
               dat_o[sbc_pkg::CTL_CRSEL] <= ctl.crsel;
            end
            sbc_pkg::IDX_STATE_CODE: begin
               dat_o[7:0] <= {code, 3'h0};
            end
            sbc_pkg::IDX_IRQ_STATUS: begin
               dat_o[sbc_pkg::EV_W-1:0] <= ev_sts;
            end
            sbc_pkg::IDX_IRQ_MASK: begin
               dat_o[sbc_pkg::EV_W-1:0] <= ev_mask;
            end
            sbc_pkg::IDX_IRQ_ENABLE: begin
               dat_o[1:0] <= ien;
            end
            default: begin
               dat_o <= '0;
            end
         endcase
      end
   end
endmodule

/* rtl/sbc_pkg.sv */
// Shared constants and types of the serial bus control block
package sbc_pkg;
   // Printed register indices; byte address is four times the index
   localparam logic [7:0] IDX_CONTROL = 8'hD8;
   localparam logic [7:0] IDX_STATE_CODE = 8'hD9;
   localparam logic [7:0] IDX_IRQ_STATUS = 8'hE0;
   localparam logic [7:0] IDX_IRQ_MASK = 8'hE1;
   localparam logic [7:0] IDX_IRQ_ENABLE = 8'hE2;
   // Control register bit positions
   localparam int CTL_CRSEL = 0;
   localparam int CTL_AA = 2;
   localparam int CTL_SI = 3;
   localparam int CTL_STOP = 4;
   localparam int CTL_START = 5;
   localparam int CTL_ON = 6;
   // Interrupt enable register bit positions
   localparam int IEN_SERIAL = 0;
   localparam int IEN_GLOBAL = 1;
   // Event bit positions in status and mask registers
   localparam int EV_STATE = 0;
   localparam int EV_STOP = 1;
   localparam int EV_RECOVER = 2;
   localparam int EV_W = 3;
   // State codes, upper five bits of the state code register
   localparam logic [4:0] CODE_IDLE = 5'h1F;
   localparam logic [4:0] CODE_START = 5'h01;
   localparam logic [4:0] CODE_RESTART = 5'h02;
   localparam logic [4:0] CODE_RESET = 5'h00;
   // Half period of the internal bit clock
   localparam int HALF_NS = 5000;
   localparam int CLK_NS = 8;
   localparam int HALF_CYC = (HALF_NS / CLK_NS) < 1 ? 1 : HALF_NS / CLK_NS;
   // Control bits kept by the block
   typedef struct packed {
      logic interface_on;
      logic start_request;
      logic stop_request;
      logic si;
      logic aa;
      logic crsel;
   } sbc_ctl_t;
   // Two-wire pin level pair
   typedef struct packed {
      logic scl;
      logic sda;
   } sbc_pins_t;
   // Master sequencer states
   typedef enum logic [3:0] {
      ST_IDLE = 4'h0,
      ST_WAIT_FREE = 4'h1,
      ST_WAIT_HALF = 4'h2,
      ST_START = 4'h3,
      ST_OWN = 4'h4,
      ST_RS_SDA = 4'h5,
      ST_RS_SCL = 4'h6,
      ST_STOP_LOW = 4'h7,
      ST_STOP_SCL = 4'h8,
      ST_STOP_SDA = 4'h9
   } sbc_state_t;
endpackage

/* rtl/sbc_sync.sv */
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module sbc_sync #(
   parameter logic INIT = 1'b1
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic arst_n,
   // Pin and filtered level
   input wire logic pin,
   output logic level
);
   logic ff1;
   logic ff2;
   logic ff3;

   // Chain; only ff2 reads ff1
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         ff1 <= INIT;
         ff2 <= INIT;
         ff3 <= INIT;
      end else begin
         ff1 <= pin;
         ff2 <= ff1;
         ff3 <= ff2;
      end
   end

   // Level moves only once stages two and three agree
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         level <= INIT;
      end else if (ff2 == ff3) begin
         level <= ff3;
      end
   end
endmodule

/* verification/sbc_ctrl_assertions.sv */
// Port-level checks of the serial bus control block
`timescale 1ns/1ps
module sbc_ctrl_assertions #(
   parameter int HALF = 4
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic arst_n,
   // Register bus
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [11:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   input wire logic ack_o,
   // Two-wire bus
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic scl_out,
   input wire logic sda_out,
   input wire logic scl_oe,
   input wire logic sda_oe
);
   localparam int HMAX = HALF + 2;
   logic on_q;
   logic start_q;
   logic busy_q;
   logic wr_ctl;
   // Control write taken this edge
   assign wr_ctl = cyc_i && stb_i && we_i && sel_i[0] && !ack_o && adr_i[9:2] == sbc_pkg::IDX_CONTROL;
   // Shadow of enable and start bits as software wrote them
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         on_q <= 1'b0;
         start_q <= 1'b0;
      end else if (wr_ctl) begin
         on_q <= dat_i[sbc_pkg::CTL_ON];
         start_q <= dat_i[sbc_pkg::CTL_START];
      end
   end
   // Foreign START marks the bus busy until a STOP on the wires
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         busy_q <= 1'b0;
      end else if ($fell(sda_in) && scl_in && !sda_oe) begin
         busy_q <= 1'b1;
      end else if ($rose(sda_in) && scl_in) begin
         busy_q <= 1'b0;
      end
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!arst_n);
   sequence s_own_start;
      $rose(sda_oe) && !scl_oe;
   endsequence
   sequence s_freed;
      $rose(sda_in) && scl_in && busy_q;
   endsequence
   AST_ACK_PULSE: assert property (ack_o |=> !ack_o) else $error("ack held too long");
   AST_ACK_TAKEN: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("request not answered");
   AST_OPEN_DRAIN: assert property (!scl_out && !sda_out) else $error("pin driven high");
   AST_OFF_RELEASE: assert property (!on_q [*3] |-> !scl_oe && !sda_oe)
      else $error("wires held while disabled");
   AST_NO_UNASKED_START: assert property (s_own_start |-> start_q)
      else $error("start without request");
   AST_START_SCL: assert property (s_own_start |-> ##[1:HMAX] scl_oe)
      else $error("clock not pulled after start");
   AST_BUSY_WAIT: assert property (busy_q |-> !sda_oe)
      else $error("start on busy bus");
   AST_HALF_GAP: assert property (s_freed |=> !sda_oe [*4])
      else $error("start too soon after stop");
   AST_SCL_HOLD: assert property ($rose(scl_oe) |=> scl_oe [*3])
      else $error("clock released too soon");
endmodule

/* verification/sbc_bus_peer.sv */
// Another master on the two-wire bus, with pull-up wires
`timescale 1ns/1ps
module sbc_bus_peer (
   // Clock and request to own the bus
   input wire logic mclk,
   input wire logic hold,
   // Block's pull-downs and resolved wires
   input wire logic dut_scl_oe,
   input wire logic dut_sda_oe,
   output logic scl_w,
   output logic sda_w
);
   logic p_scl = 1'b0;
   logic p_sda = 1'b0;
   // Pull-ups win only when nobody pulls low
   assign scl_w = !(p_scl || dut_scl_oe);
   assign sda_w = !(p_sda || dut_sda_oe);
   // START on hold rise, clock runs at 160 ns while held, STOP on hold fall
   always @(posedge mclk) begin
      if (hold && !p_sda) begin
         p_sda <= 1'b1;
         repeat (10) @(posedge mclk);
         p_scl <= 1'b1;
      end else if (hold) begin
         repeat (9) @(posedge mclk);
         // Re-check so a late toggle never glitches the wire
         if (hold) begin
            p_scl <= !p_scl;
         end
      end else if (p_sda) begin
         p_scl <= 1'b0;
         repeat (10) @(posedge mclk);
         p_sda <= 1'b0;
      end
   end
endmodule

/* verification/tb.sv */
// Self-checking bench of the serial bus control block
`timescale 1ns/1ps
module tb;
   localparam logic [7:0] a_ctl = sbc_pkg::IDX_CONTROL;
   localparam logic [7:0] a_code = sbc_pkg::IDX_STATE_CODE;
   localparam logic [7:0] a_st = sbc_pkg::IDX_IRQ_STATUS;
   localparam logic [7:0] a_msk = sbc_pkg::IDX_IRQ_MASK;
   localparam logic [7:0] a_ien = sbc_pkg::IDX_IRQ_ENABLE;
   logic mclk = 1'b0;
   logic arst_n = 1'b0;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic hold = 1'b0;
   logic [11:0] adr = 12'h000;
   logic [3:0] sel = 4'h0;
   logic [31:0] dat = 32'h0;
   logic [31:0] dat_o;
   logic ack, scl_oe, sda_oe, scl_w, sda_w, irq;
   logic [7:0] q, r;
   int failures = 0;
   int num_checks = 0;
   int cyc_n = 0;
   int m_ctl = 0;
   int m_si = 0;
   always #4 mclk = ~mclk;
   sbc_ctrl #(.HALF(4)) dut (.mclk(mclk), .arst_n(arst_n), .cyc_i(cyc), .stb_i(stb), .we_i(we),
      .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(dat_o), .ack_o(ack), .scl_in(scl_w),
      .scl_out(), .scl_oe(scl_oe), .sda_in(sda_w), .sda_out(), .sda_oe(sda_oe), .irq(irq));
   sbc_bus_peer peer (.mclk(mclk), .hold(hold), .dut_scl_oe(scl_oe), .dut_sda_oe(sda_oe),
      .scl_w(scl_w), .sda_w(sda_w));
   task automatic finish_test;
      $display("checks %0d mismatches %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   // Model of control: SI only clears by a written zero
   function automatic logic [7:0] exp_ctl();
      return 8'(m_ctl | (m_si << 3));
   endfunction
   // One classic cycle, held until ack is seen
   task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d);
      @(posedge mclk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {2'h0, idx, 2'h0};
      sel <= 4'hF;
      dat <= {24'h0, d};
      // No answer time assumed; only the hang guard ends this wait
      do begin
         @(posedge mclk);
      end while (ack !== 1'b1);
      q = dat_o[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      if (w && idx == a_ctl) begin
         m_ctl = d & 8'h75;
         if (!d[3]) m_si = 0;
      end
   endtask
   task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
      wb(1'b0, idx, 8'h00);
      chk(q, exp);
   endtask
   // Bounded wait on a pin condition, then settle past the synchroniser
   task automatic waitc(input int k);
      int n;
      n = 0;
      while (n < 300 && !((k == 0 && scl_oe === 1'b1) || (k == 1 && scl_oe === 1'b0)
            || (k == 3 && sda_oe === 1'b0 && scl_oe === 1'b0))) begin
         @(posedge mclk);
         n++;
      end
      if (n >= 300) begin
         failures++;
         $display("MISMATCH t=%0t pin wait", $time);
      end
      repeat (8) @(posedge mclk);
   endtask
   task automatic irq_is(input logic [7:0] exp);
      repeat (3) @(posedge mclk);
      chk(8'(irq), exp);
   endtask
   // Hang guard, far above the few hundred cycles needed
   always @(posedge mclk) begin
      cyc_n++;
      if (cyc_n == 20000) begin
         failures++;
         $display("MISMATCH t=%0t timeout", $time);
         finish_test;
      end
   end
   initial begin
      r = 8'($urandom(32'h0aa82847));
      repeat (12) @(posedge mclk);
      arst_n <= 1'b1;
      rd(a_ctl, 8'h00);
      rd(8'hF0, 8'h00);
      r = 8'($urandom);
      wb(1'b1, a_code, r);
      rd(a_code, 8'hF8);
      wb(1'b1, a_ctl, 8'h20);
      repeat (30) @(posedge mclk);
      chk(8'(sda_oe), 8'h00);
      rd(a_ctl, exp_ctl());
      // Mask bit set lets an event through; all blocked for now
      wb(1'b1, a_msk, 8'h00);
      wb(1'b1, a_ien, 8'h01);
      wb(1'b1, a_ctl, 8'h60);
      waitc(0);
      m_si = 1;
      rd(a_ctl, exp_ctl());
      rd(a_code, 8'h08);
      chk(8'(irq), 8'h00);
      wb(1'b1, a_ien, 8'h03);
      irq_is(8'h01);
      rd(a_st, 8'h01);
      repeat (20) @(posedge mclk);
      chk(8'(scl_oe), 8'h01);
      wb(1'b1, a_ctl, 8'h60);
      waitc(1);
      waitc(0);
      m_si = 1;
      rd(a_code, 8'h10);
      wb(1'b1, a_ctl, 8'h70);
      waitc(1);
      waitc(0);
      m_si = 1;
      rd(a_code, 8'h08);
      rd(a_st, 8'h03);
      wb(1'b1, a_ctl, 8'h50);
      waitc(3);
      m_ctl = m_ctl & 8'hEF;
      rd(a_ctl, exp_ctl());
      rd(a_code, 8'hF8);
      irq_is(8'h00);
      wb(1'b1, a_st, 8'h07);
      rd(a_st, 8'h00);
      wb(1'b1, a_ctl, 8'h50);
      repeat (3) @(posedge mclk);
      m_ctl = m_ctl & 8'hEF;
      rd(a_ctl, exp_ctl());
      chk(8'(sda_oe | scl_oe), 8'h00);
      rd(a_st, 8'h04);
      wb(1'b1, a_msk, 8'h0B);
      irq_is(8'h00);
      wb(1'b1, a_msk, 8'h04);
      irq_is(8'h01);
      wb(1'b1, a_st, 8'h04);
      irq_is(8'h00);
      hold <= 1'b1;
      repeat (20) @(posedge mclk);
      wb(1'b1, a_ctl, 8'h60);
      repeat (40) @(posedge mclk);
      chk(8'(sda_oe), 8'h00);
      hold <= 1'b0;
      waitc(0);
      rd(a_code, 8'h08);
      wb(1'b1, a_ctl, 8'h50);
      waitc(3);
      m_ctl = m_ctl & 8'hEF;
      rd(a_ctl, exp_ctl());
      finish_test;
   end
endmodule
bind sbc_ctrl sbc_ctrl_assertions #(.HALF(HALF)) u_chk (.mclk(mclk), .arst_n(arst_n), .cyc_i(cyc_i),
   .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .ack_o(ack_o),
   .scl_in(scl_in), .sda_in(sda_in), .scl_out(scl_out), .sda_out(sda_out), .scl_oe(scl_oe),
   .sda_oe(sda_oe));
